// *** design/sweep_defs.svh ***
// Purpose: constants of the sweep / list sequencer control block
// Assumes: 100 MHz sys_clk, AXI4-Lite word registers at 4 x index
// Notes: fields are bit positions inside the 8-bit configuration
//
// Contract
// - Source bit picks buffer or computed points
// - Direction clear: start at begin, go up
// - Direction set: start at end, go down
// - Sawtooth jumps back to initial point
// - Triangle reverses at end, returns to start
// - Software trigger only starts and stops
// - Hardware trigger is a pin falling edge
// - Start/stop runs cycles, dwelling each point
// - Trigger while running ends the sweep
// - Step mode needs hardware trigger source
// - Step mode advances one point per trigger
// - Step mode stops after cycle count
// - Trigger after step stop restarts stepping
// - Software trigger or fixed tone ends stepping
// - Return clear: stay on final point
// - Return set: go to initial point, stop
// - Trigger output pulses only when enabled
// - Mode 0: pulse after each settled change
// - Mode 1: pulse at each cycle end
// - Begin frequency is 56-bit write-only value
// - Triggers ignored in single fixed tone
// - Dwell counted in 500 us units
// - Cycle count zero repeats forever
// - Separate end frequency for computed sweeps
`ifndef SWEEP_DEFS_SVH
`define SWEEP_DEFS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define IDX_CONFIG 8'h05
`define IDX_BEGIN_LO 8'h06
`define IDX_END_LO 8'h07
`define IDX_STEP_LO 8'h08
`define IDX_DWELL 8'h09
`define IDX_CYCLES 8'h0a
`define IDX_POINTS 8'h0c
`define IDX_BEGIN_HI 8'h26
`define IDX_END_HI 8'h27
`define IDX_STEP_HI 8'h28
`define IDX_CONTROL 8'h30
`define IDX_STATUS 8'h31
`define IDX_FREQ_LO 8'h32
`define IDX_FREQ_HI 8'h33

// ****************************************
// Configuration fields and control bits
// ****************************************
`define CFG_SRC 0
`define CFG_DIR 1
`define CFG_WAVE 2
`define CFG_TRIG 3
`define CFG_STEP 4
`define CFG_RET 5
`define CFG_OEN 6
`define CFG_OMODE 7
`define CTL_TONE 0
`define CTL_SWTRIG 1

// ****************************************
// Reset values and bus answers
// ****************************************
`define CONFIG_RST 8'h00
`define FREQ_RST 56'h0
`define WORD_RST 32'h0
`define POINTS_RST 16'h0001
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 100
`define DWELL_UNIT_US 500
`define DWELL_TICK_CYC (`DWELL_UNIT_US * `CLK_MHZ)
`define SETTLE_NS 100
`define SETTLE_CYC ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define PULSE_NS 1000
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

// *** design/sweep_pkg.sv ***
// Purpose: types shared by the sweep sequencer files
// Assumes: nothing
// Notes: one-hot state codes
package sweep_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DWELL = 3'b010,
      ST_STEP = 3'b100
   } seq_state_t;
endpackage

// *** design/trig_in_sync.sv ***
// Purpose: bring trigger_in_pin into sys_clk, flag falling edges
// Assumes: pin is asynchronous to sys_clk
// Notes: a level change counts once stages two and three agree
module trig_in_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Pin and event
   input wire logic pin,
   output logic fall
);
   logic [2:0] stage;
   logic level;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stage <= 3'h7;
      end else begin
         stage <= {stage[1:0], pin};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         level <= 1'b1;
         fall <= 1'b0;
      end else begin
         fall <= 1'b0;
         if (stage[1] == stage[2]) begin
            level <= stage[2];
            fall <= level & ~stage[2];
         end
      end
   end
endmodule

// *** design/trig_out_pulse.sv ***
// Purpose: timed pulse on trigger_out_pin per qualifying event
// Assumes: events come no closer than one settle delay plus one pulse apart
// Notes: a settle delay precedes the pulse; events while busy drop
`include "sweep_defs.svh"
module trig_out_pulse (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Event in, pin out
   input wire logic fire,
   output logic pin
);
   localparam logic [7:0] TOTAL = 8'(`SETTLE_CYC + `PULSE_CYC);
   localparam logic [7:0] PULSE = 8'(`PULSE_CYC);
   logic [7:0] cnt;
   logic [7:0] next_cnt;

   always_comb begin
      next_cnt = cnt;
      if (cnt != 8'h00) begin
         next_cnt = cnt - 8'h01;
      end else if (fire) begin
         next_cnt = TOTAL;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt <= 8'h00;
         pin <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pin <= (next_cnt != 8'h00) && (next_cnt <= PULSE);
      end
   end
endmodule

// *** design/sweep_list_sequencer_control.sv ***
// Purpose: steps a frequency source through buffer or computed points
// Assumes: AXI4-Lite register access, one clock, synchronous reset
// Notes: in buffer mode point_index addresses an outside point store
//
// The AXI4-Lite slave port is this design's own decision.
`include "sweep_defs.svh"
module sweep_list_sequencer_control #(
   parameter int DWELL_TICK_CYC = `DWELL_TICK_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // AXI4-Lite write
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Trigger pins
   input wire logic trigger_in_pin,
   output logic trigger_out_pin,
   // Point output
   output logic [55:0] freq_word,
   output logic [15:0] point_index,
   output logic sweep_running
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] reg_index(input logic [11:0] a);
      reg_index = a[9:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] i);
      is_mapped = (i == `IDX_CONFIG) || (i == `IDX_BEGIN_LO) ||
         (i == `IDX_END_LO) || (i == `IDX_STEP_LO) ||
         (i == `IDX_DWELL) || (i == `IDX_CYCLES) ||
         (i == `IDX_POINTS) || (i == `IDX_BEGIN_HI) ||
         (i == `IDX_END_HI) || (i == `IDX_STEP_HI) ||
         (i == `IDX_CONTROL) || (i == `IDX_STATUS) ||
         (i == `IDX_FREQ_LO) || (i == `IDX_FREQ_HI);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] din, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = din[b*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   logic aw_held;
   logic w_held;
   logic [7:0] wr_idx;
   logic [31:0] wr_data;
   logic [3:0] wr_be;
   logic do_wr;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   assign do_wr = aw_held & w_held & ~bvalid;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         awready <= 1'b1;
         aw_held <= 1'b0;
         wr_idx <= 8'h00;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         wr_idx <= reg_index(awaddr);
      end else if (bvalid && bready) begin
         awready <= 1'b1;
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wready <= 1'b1;
         w_held <= 1'b0;
         wr_data <= `WORD_RST;
         wr_be <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held <= 1'b1;
         wr_data <= wdata;
         wr_be <= wstrb;
      end else if (bvalid && bready) begin
         wready <= 1'b1;
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         bresp <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= `WORD_RST;
         rresp <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] sweep_config;
   logic [55:0] sweep_begin_frequency;
   logic [55:0] sweep_end_frequency;
   logic [55:0] step_frequency;
   logic [31:0] dwell_value;
   logic [31:0] cycle_count;
   logic [15:0] buffer_points;
   logic output_tone_select;
   logic sw_trig;
   logic [31:0] status_word;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sweep_config <= `CONFIG_RST;
         sweep_begin_frequency <= `FREQ_RST;
         sweep_end_frequency <= `FREQ_RST;
         step_frequency <= `FREQ_RST;
         dwell_value <= `WORD_RST;
         cycle_count <= `WORD_RST;
         buffer_points <= `POINTS_RST;
         output_tone_select <= 1'b0;
      end else if (do_wr) begin
         if (wr_idx == `IDX_CONFIG) begin
            sweep_config <= 8'(merge(32'(sweep_config), wr_data, wr_be));
         end else if (wr_idx == `IDX_BEGIN_LO) begin
            sweep_begin_frequency[31:0] <=
               merge(sweep_begin_frequency[31:0], wr_data, wr_be);
         end else if (wr_idx == `IDX_BEGIN_HI) begin
            sweep_begin_frequency[55:32] <= 24'(merge(
               32'(sweep_begin_frequency[55:32]), wr_data, wr_be));
         end else if (wr_idx == `IDX_END_LO) begin
            sweep_end_frequency[31:0] <=
               merge(sweep_end_frequency[31:0], wr_data, wr_be);
         end else if (wr_idx == `IDX_END_HI) begin
            sweep_end_frequency[55:32] <= 24'(merge(
               32'(sweep_end_frequency[55:32]), wr_data, wr_be));
         end else if (wr_idx == `IDX_STEP_LO) begin
            step_frequency[31:0] <=
               merge(step_frequency[31:0], wr_data, wr_be);
         end else if (wr_idx == `IDX_STEP_HI) begin
            step_frequency[55:32] <= 24'(merge(
               32'(step_frequency[55:32]), wr_data, wr_be));
         end else if (wr_idx == `IDX_DWELL) begin
            dwell_value <= merge(dwell_value, wr_data, wr_be);
         end else if (wr_idx == `IDX_CYCLES) begin
            cycle_count <= merge(cycle_count, wr_data, wr_be);
         end else if (wr_idx == `IDX_POINTS) begin
            buffer_points <= 16'(merge(32'(buffer_points), wr_data,
               wr_be));
         end else if (wr_idx == `IDX_CONTROL && wr_be[0]) begin
            output_tone_select <= wr_data[`CTL_TONE];
         end
      end
   end

   // Software trigger is a one-cycle pulse from a control write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sw_trig <= 1'b0;
      end else begin
         sw_trig <= do_wr && wr_idx == `IDX_CONTROL && wr_be[0] &&
            wr_data[`CTL_SWTRIG];
      end
   end

   // Write-only registers read back as zero
   always_comb begin
      next_rdata = `WORD_RST;
      next_rresp = `RESP_OKAY;
      if (!is_mapped(reg_index(araddr))) begin
         next_rresp = `RESP_SLVERR;
      end else if (reg_index(araddr) == `IDX_STATUS) begin
         next_rdata = status_word;
      end else if (reg_index(araddr) == `IDX_FREQ_LO) begin
         next_rdata = freq_word[31:0];
      end else if (reg_index(araddr) == `IDX_FREQ_HI) begin
         next_rdata = 32'(freq_word[55:32]);
      end else if (reg_index(araddr) == `IDX_CONTROL) begin
         next_rdata = 32'(output_tone_select);
      end
   end

   // ****************************************
   // Triggers
   // ****************************************
   sweep_pkg::seq_state_t state;
   logic pin_fall;
   logic hw_src;
   logic trig;
   logic step_mode;
   logic list_src;

   trig_in_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin(trigger_in_pin),
      .fall(pin_fall)
   );

   assign hw_src = sweep_config[`CFG_TRIG];
   // Fixed tone mode masks every trigger
   assign trig = output_tone_select &
      (hw_src ? pin_fall : sw_trig);
   assign step_mode = sweep_config[`CFG_STEP] & hw_src;
   assign list_src = ~sweep_config[`CFG_SRC];

   // ****************************************
   // Point stepping
   // ****************************************
   logic dir_up;
   logic leg;
   logic [31:0] cycles_done;
   logic [15:0] last_idx;
   logic at_top;
   logic at_bot;
   logic at_edge;
   logic [56:0] sum_up;
   logic [56:0] floor_dn;
   logic [55:0] up_freq;
   logic [55:0] dn_freq;
   logic start;
   logic adv;
   logic move;
   logic load_init;
   logic cyc_end;
   logic finish;
   logic next_dir;
   logic next_leg;
   logic last_cycle;
   logic dwell_done;

   assign last_idx = (buffer_points == 16'h0000) ? 16'h0000 :
      buffer_points - 16'h0001;
   assign sum_up = {1'b0, freq_word} + {1'b0, step_frequency};
   assign floor_dn = {1'b0, sweep_begin_frequency} +
      {1'b0, step_frequency};
   assign up_freq = (sum_up > {1'b0, sweep_end_frequency}) ?
      sweep_end_frequency : sum_up[55:0];
   assign dn_freq = ({1'b0, freq_word} < floor_dn) ?
      sweep_begin_frequency : freq_word - step_frequency;
   assign at_top = list_src ? (point_index >= last_idx) :
      (freq_word >= sweep_end_frequency);
   assign at_bot = list_src ? (point_index == 16'h0000) :
      (freq_word <= sweep_begin_frequency);
   assign at_edge = dir_up ? at_top : at_bot;
   assign last_cycle = (cycle_count != `WORD_RST) &&
      (cycles_done + 32'h1 >= cycle_count);

   assign start = state == sweep_pkg::ST_IDLE && trig;
   assign adv = (state == sweep_pkg::ST_DWELL && dwell_done && !trig) ||
      (state == sweep_pkg::ST_STEP && trig);

   always_comb begin
      move = 1'b0;
      load_init = start;
      cyc_end = 1'b0;
      finish = 1'b0;
      next_dir = dir_up;
      next_leg = leg;
      if (adv) begin
         if (!at_edge) begin
            move = 1'b1;
         end else if (sweep_config[`CFG_WAVE] && !leg) begin
            next_dir = ~dir_up;
            next_leg = 1'b1;
            move = 1'b1;
         end else begin
            cyc_end = 1'b1;
            if (last_cycle) begin
               finish = 1'b1;
               load_init = sweep_config[`CFG_RET];
            end else if (sweep_config[`CFG_WAVE]) begin
               next_dir = ~dir_up;
               next_leg = 1'b0;
               move = 1'b1;
            end else begin
               load_init = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         freq_word <= `FREQ_RST;
         point_index <= 16'h0000;
         dir_up <= 1'b1;
         leg <= 1'b0;
      end else if (load_init) begin
         dir_up <= ~sweep_config[`CFG_DIR];
         leg <= 1'b0;
         if (sweep_config[`CFG_DIR]) begin
            freq_word <= sweep_end_frequency;
            point_index <= last_idx;
         end else begin
            freq_word <= sweep_begin_frequency;
            point_index <= 16'h0000;
         end
      end else if (move) begin
         dir_up <= next_dir;
         leg <= next_leg;
         if (!list_src) begin
            freq_word <= next_dir ? up_freq : dn_freq;
         end else begin
            point_index <= next_dir ? point_index + 16'h0001 :
               point_index - 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cycles_done <= `WORD_RST;
      end else if (start) begin
         cycles_done <= `WORD_RST;
      end else if (cyc_end) begin
         cycles_done <= cycles_done + 32'h1;
      end
   end

   // ****************************************
   // Sequencer state
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= sweep_pkg::ST_IDLE;
      end else if (!output_tone_select) begin
         state <= sweep_pkg::ST_IDLE;
      end else begin
         case (state)
            sweep_pkg::ST_IDLE: begin
               if (start) begin
                  state <= step_mode ? sweep_pkg::ST_STEP :
                     sweep_pkg::ST_DWELL;
               end
            end
            sweep_pkg::ST_DWELL: begin
               if (trig || finish) begin
                  state <= sweep_pkg::ST_IDLE;
               end
            end
            sweep_pkg::ST_STEP: begin
               if (sw_trig || finish) begin
                  state <= sweep_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= sweep_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sweep_running <= 1'b0;
      end else begin
         sweep_running <= state != sweep_pkg::ST_IDLE;
      end
   end

   assign status_word = {cycles_done[15:0], 11'h000, leg, dir_up,
      state};

   // ****************************************
   // Dwell timer
   // ****************************************
   logic [31:0] tick_cnt;
   logic [31:0] dwell_cnt;
   logic tick;

   assign tick = tick_cnt == 32'(DWELL_TICK_CYC - 1);
   assign dwell_done = tick && (dwell_cnt + 32'h1 >= dwell_value);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tick_cnt <= `WORD_RST;
         dwell_cnt <= `WORD_RST;
      end else if (state != sweep_pkg::ST_DWELL || load_init || move) begin
         tick_cnt <= `WORD_RST;
         dwell_cnt <= `WORD_RST;
      end else if (tick) begin
         tick_cnt <= `WORD_RST;
         dwell_cnt <= dwell_cnt + 32'h1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end

   // ****************************************
   // Trigger output
   // ****************************************
   logic chg_d;
   logic cyc_d;
   logic fire;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chg_d <= 1'b0;
         cyc_d <= 1'b0;
      end else begin
         chg_d <= load_init | move;
         cyc_d <= cyc_end;
      end
   end

   // Point change is taken one cycle after the point registers load
   assign fire = sweep_config[`CFG_OEN] & (sweep_config[`CFG_OMODE] ?
      cyc_d : chg_d);

   trig_out_pulse u_pulse (
      .sys_clk(sys_clk),
      .rst(rst),
      .fire(fire),
      .pin(trigger_out_pin)
   );

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence start_s;
      state == sweep_pkg::ST_IDLE && trig;
   endsequence

   sequence fire_off_s;
      !sweep_config[`CFG_OEN] && u_pulse.cnt == 8'h00;
   endsequence

   stop_on_trig_a: assert property (
      state == sweep_pkg::ST_DWELL && trig |=> state == sweep_pkg::ST_IDLE)
      else $error("running sweep did not stop on trigger");
   soft_no_step_a: assert property (
      start_s ##0 !hw_src |=> state == sweep_pkg::ST_DWELL)
      else $error("software trigger entered stepping");
   fixed_tone_a: assert property (
      !output_tone_select |-> !trig ##1 state == sweep_pkg::ST_IDLE)
      else $error("sequencer active in fixed tone");
   start_up_a: assert property (
      start_s ##0 !sweep_config[`CFG_DIR] |=>
      freq_word == $past(sweep_begin_frequency) && point_index == 16'h0)
      else $error("forward sweep did not begin at start point");
   start_down_a: assert property (
      start_s ##0 sweep_config[`CFG_DIR] |=>
      freq_word == $past(sweep_end_frequency) && !dir_up)
      else $error("reverse sweep did not begin at end point");
   step_hold_a: assert property (
      state == sweep_pkg::ST_STEP && !trig |=>
      $stable(freq_word) && $stable(point_index))
      else $error("stepping moved without a trigger");
   count_stop_a: assert property (
      cyc_end && last_cycle |=> state == sweep_pkg::ST_IDLE)
      else $error("sweep kept running past cycle count");
   return_start_a: assert property (
      finish && sweep_config[`CFG_RET] && !sweep_config[`CFG_DIR] |=>
      freq_word == $past(sweep_begin_frequency))
      else $error("return to start missed");
   out_quiet_a: assert property (
      fire_off_s |=> u_pulse.cnt == 8'h00 && !trigger_out_pin)
      else $error("output pulse started while disabled");
   cycle_pulse_a: assert property (
      cyc_end ##1 sweep_config[`CFG_OEN] && sweep_config[`CFG_OMODE] |->
      fire)
      else $error("no output event at cycle end");
endmodule

// *** tb/trig_source.sv ***
// Purpose: external trigger equipment on trigger_in_pin
// Assumes: pin idles high
// Notes: each fire gives one falling edge, each level held 8 cycles
module trig_source (
   // Clock
   input wire logic sys_clk,
   // Pin
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'h1;
   // Long levels so the input synchroniser sees one edge
   task fire;
      @(posedge sys_clk);
      pin <= 1'h0;
      repeat (8) @(posedge sys_clk);
      pin <= 1'h1;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

// *** tb/test_sweep_list_sequencer_control.sv ***
// Purpose: self-checking bench of the sweep sequencer control
// Assumes: DWELL_TICK_CYC cut to 10 cycles
// Notes: read results are checked from a queue by a monitor
`include "sweep_defs.svh"
module test_sweep_list_sequencer_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'h0, rst = 1'h1, last = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, b, rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, pin, tout, run;
   logic [55:0] freq;
   logic [15:0] pidx;
   logic [63:0] e;
   logic [63:0] rq[$];
   logic [1:0] bq[$];
   logic [7:0] cfg[5] = '{8'h41, 8'h03, 8'h21, 8'h05, 8'hc1};
   logic [7:0] fin[5] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h20};
   int mismatches = 0, check_count = 0, pulses = 0, p0, seed = 32'haa3c;
   sweep_list_sequencer_control #(.DWELL_TICK_CYC(10)) DUT (
      .sys_clk(sys_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .trigger_in_pin(pin), .trigger_out_pin(tout), .freq_word(freq),
      .point_index(pidx), .sweep_running(run));
   trig_source src (.sys_clk(sys_clk), .pin(pin));
   initial forever #5 sys_clk = ~sys_clk;
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task wr(input [7:0] i, input [31:0] d, input [1:0] r);
      bq.push_back(r);
      @(posedge sys_clk);
      awaddr <= {2'h0, i, 2'h0};
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
   endtask
   task rd(input [7:0] i, input [31:0] x, input [31:0] m);
      rq.push_back({m, x & m});
      @(posedge sys_clk);
      araddr <= {2'h0, i, 2'h0};
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
   endtask
   task setup(input [7:0] c, input [31:0] dw);
      wr(`IDX_CONFIG, {24'h0, c}, `RESP_OKAY);
      wr(`IDX_BEGIN_LO, b, `RESP_OKAY);
      wr(`IDX_END_LO, b + 32'h20, `RESP_OKAY);
      wr(`IDX_STEP_LO, 32'h10, `RESP_OKAY);
      wr(`IDX_DWELL, dw, `RESP_OKAY);
      wr(`IDX_CYCLES, 32'h1, `RESP_OKAY);
      wr(`IDX_CONTROL, 32'h1, `RESP_OKAY);
   endtask
   always @(posedge sys_clk) begin
      last <= tout;
      if (tout && !last) pulses <= pulses + 1;
      if (rvalid && rready) begin
         e = rq.pop_front();
         check_count++;
         if ((rdata & e[63:32]) !== e[31:0]) begin
            mismatches++;
            $display("mismatch rdata exp %h got %h", e[31:0], rdata);
         end
      end
      if (bvalid && bready) begin
         check_count++;
         if (bresp !== bq[0]) begin
            mismatches++;
            $display("mismatch bresp exp %h got %h", bq[0], bresp);
         end
         bq.pop_front();
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'h0;
      b = $random(seed) & 32'hffff;
      rd(`IDX_STATUS, 32'h9, 32'hffffffff);
      wr(8'h0b, 32'h0, `RESP_SLVERR);
      wr(`IDX_BEGIN_LO, b, `RESP_OKAY);
      rd(`IDX_BEGIN_LO, 32'h0, 32'hffffffff);
      wr(`IDX_CONTROL, 32'h2, `RESP_OKAY);
      repeat (20) @(posedge sys_clk);
      rd(`IDX_STATUS, 32'h1, 32'h7);
      $display("test 0 done");
      for (int t = 0; t < 5; t++) begin
         setup(cfg[t], 32'h1);
         p0 = pulses;
         wr(`IDX_CONTROL, 32'h3, `RESP_OKAY);
         repeat (10) @(posedge sys_clk);
         for (int i = 0; i < 900 && run; i++) @(posedge sys_clk);
         repeat (150) @(posedge sys_clk);
         rd(`IDX_FREQ_LO, b + fin[t], '1);
         check_count++;
         if ((pulses != p0) !== cfg[t][6]) begin
            mismatches++;
            $display("mismatch pulses exp %h got %0d", cfg[t][6], pulses - p0);
         end
         $display("test %0d done", t + 1);
      end
      setup(8'h01, 32'd100);
      wr(`IDX_CONTROL, 32'h3, `RESP_OKAY);
      repeat (30) @(posedge sys_clk);
      rd(`IDX_STATUS, 32'h2, 32'h7);
      wr(`IDX_CONTROL, 32'h3, `RESP_OKAY);
      repeat (10) @(posedge sys_clk);
      rd(`IDX_STATUS, 32'h1, 32'h7);
      $display("test 6 done");
      setup(8'h19, 32'h1);
      src.fire;
      src.fire;
      rd(`IDX_FREQ_LO, b + 32'h10, '1);
      rd(`IDX_STATUS, 32'h4, 32'h7);
      wr(`IDX_CONTROL, 32'h3, `RESP_OKAY);
      repeat (10) @(posedge sys_clk);
      rd(`IDX_STATUS, 32'h1, 32'h7);
      $display("test 7 done");
      setup(8'h00, 32'h1);
      wr(`IDX_POINTS, 32'h3, `RESP_OKAY);
      wr(`IDX_CONTROL, 32'h3, `RESP_OKAY);
      repeat (10) @(posedge sys_clk);
      for (int i = 0; i < 900 && run; i++) @(posedge sys_clk);
      check_count++;
      if (pidx !== 16'h2) begin
         mismatches++;
         $display("mismatch point_index exp 2 got %0d", pidx);
      end
      rd(`IDX_FREQ_LO, b + 32'h10, '1);
      $display("test 8 done");
      end_of_test;
   end
endmodule
